//--- design/pwmpt_pkg.sv
// Package for the PWM phase, trigger and output control block.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package pwmpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_PRI_PHASE = 6'h00;
  localparam logic [5:0] OFS_SEC_PHASE = 6'h04;
  localparam logic [5:0] OFS_IO_CTRL = 6'h08;
  localparam logic [5:0] OFS_TRIG_CMP = 6'h0C;
  localparam logic [5:0] OFS_GEN_CTRL = 6'h10;
  localparam logic [5:0] OFS_UNLOCK = 6'h14;
  localparam logic [5:0] OFS_PERIOD = 6'h18;
  localparam logic [5:0] OFS_DUTY = 6'h1C;
  localparam logic [5:0] OFS_STATUS = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int GEN_ON_BIT = 0;
  localparam int GEN_ITB_BIT = 9;
  localparam int IO_OVERRIDE_SYNC_BIT = 0;
  localparam int IO_SWAP_BIT = 1;
  localparam int IO_OVVAL_L_BIT = 6;
  localparam int IO_OVVAL_H_BIT = 7;
  localparam int IO_OVEN_L_BIT = 8;
  localparam int IO_OVEN_H_BIT = 9;
  localparam int IO_OUTPUT_PAIR_MODE_LSB = 10;
  localparam int STAT_OPEN_BIT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and unlock keys
  localparam logic [15:0] RST_PRI_PHASE = 16'h0000;
  localparam logic [15:0] RST_SEC_PHASE = 16'h0000;
  localparam logic [15:0] RST_IO_CTRL = 16'h0000;
  localparam logic [15:0] RST_TRIG_CMP = 16'h0000;
  localparam logic [15:0] RST_GEN_CTRL = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_DUTY = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY1 = 16'hABCD;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h4321;

  ////////////////////////////////////////////////////////////////////////////
  // Output pair modes and unlock states
  typedef enum logic [1:0] {
    OUTPUT_PAIR_MODE_COMPL,
    OUTPUT_PAIR_MODE_REDUN,
    OUTPUT_PAIR_MODE_PUSHPULL,
    OUTPUT_PAIR_MODE_INDEP
  } pwmpt_output_pair_mode_t;

  typedef enum logic [1:0] {
    UL_IDLE,
    UL_KEY1,
    UL_OPEN
  } pwmpt_ulk_t;

endpackage

//--- design/pwmpt_timebase.sv
// Up counter with period wrap and phase load, one per output time base.
// Assumes load and period come from logic on the same clock.
`timescale 1ns/1ps
module pwmpt_timebase #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] period,
  // Status
  output logic [W-1:0] cnt_q,
  output logic wrap
);

  assign wrap = run && (cnt_q >= period);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

endmodule

//--- design/pwmpt_top.sv
// PWM generator: phase and secondary phase, output modes, swap, override
// sync, write lock and ADC trigger compare behind an Avalon-MM slave.
// Assumes pwm_write_lock is a static configuration level on this clock.
`timescale 1ns/1ps
module pwmpt_top
  import pwmpt_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [pwmpt_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration
  input wire logic pwm_write_lock,
  // Power stage and ADC
  output logic high_side_output,
  output logic low_side_output,
  output logic adc_trigger
);
  import pwmpt_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] primary_phase_value_q;
  logic [15:0] secondary_phase_value_q;
  logic [15:0] output_io_control_q;
  logic [15:0] trigger_compare_value_q;
  logic [15:0] generator_control_q;
  logic [15:0] period_q;
  logic [15:0] duty_q;
  pwmpt_ulk_t unlock_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;

  function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: waitrequest drops for one cycle, one cycle after request
  logic req;
  logic wr_ok;
  logic [5:0] word_addr;
  assign req = avs_read || avs_write;
  assign wr_ok = avs_write && !waitrequest_q;
  assign word_addr = {avs_address[5:2], 2'b00};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= !(req && waitrequest_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequence for the output control register
  logic io_wr_allowed;
  assign io_wr_allowed = !pwm_write_lock || (unlock_q == UL_OPEN);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_q <= UL_IDLE;
    end else if (wr_ok && word_addr == OFS_UNLOCK) begin
      unique case (unlock_q)
        UL_IDLE: begin
          unlock_q <= (avs_writedata[15:0] == UNLOCK_KEY1) ? UL_KEY1 : UL_IDLE;
        end
        UL_KEY1: begin
          unlock_q <= (avs_writedata[15:0] == UNLOCK_KEY2) ? UL_OPEN : UL_IDLE;
        end
        UL_OPEN: begin
          unlock_q <= UL_OPEN;
        end
        default: begin
          unlock_q <= UL_IDLE;
        end
      endcase
    end else if (wr_ok && word_addr == OFS_IO_CTRL) begin
      // One unlock opens exactly one write attempt
      unlock_q <= UL_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_phase_value_q <= RST_PRI_PHASE;
      secondary_phase_value_q <= RST_SEC_PHASE;
      trigger_compare_value_q <= RST_TRIG_CMP;
      generator_control_q <= RST_GEN_CTRL;
      period_q <= RST_PERIOD;
      duty_q <= RST_DUTY;
    end else if (wr_ok) begin
      unique case (word_addr)
        OFS_PRI_PHASE: begin
          primary_phase_value_q <= be_merge(primary_phase_value_q, avs_writedata,
                                            avs_byteenable);
        end
        OFS_SEC_PHASE: begin
          secondary_phase_value_q <= be_merge(secondary_phase_value_q, avs_writedata,
                                              avs_byteenable);
        end
        OFS_TRIG_CMP: begin
          trigger_compare_value_q <= be_merge(trigger_compare_value_q, avs_writedata,
                                              avs_byteenable);
        end
        OFS_GEN_CTRL: begin
          generator_control_q <= be_merge(generator_control_q, avs_writedata,
                                          avs_byteenable);
        end
        OFS_PERIOD: begin
          period_q <= be_merge(period_q, avs_writedata, avs_byteenable);
        end
        OFS_DUTY: begin
          duty_q <= be_merge(duty_q, avs_writedata, avs_byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  // Swap and override sync are not guarded against change while running;
  // software is trusted to set them before enabling.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_io_control_q <= RST_IO_CTRL;
    end else if (wr_ok && word_addr == OFS_IO_CTRL && io_wr_allowed) begin
      output_io_control_q <= be_merge(output_io_control_q, avs_writedata,
                                      avs_byteenable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls
  logic pwm_module_on;
  logic independent_timebase_sel;
  logic override_sync;
  logic swap;
  pwmpt_output_pair_mode_t output_pair_mode;
  logic indep;
  logic [1:0] ov_en_wr;
  logic [1:0] override_value_wr;
  assign pwm_module_on = generator_control_q[GEN_ON_BIT];
  assign independent_timebase_sel = generator_control_q[GEN_ITB_BIT];
  assign override_sync = output_io_control_q[IO_OVERRIDE_SYNC_BIT];
  assign swap = output_io_control_q[IO_SWAP_BIT];
  assign output_pair_mode = pwmpt_output_pair_mode_t'(output_io_control_q[IO_OUTPUT_PAIR_MODE_LSB +: 2]);
  assign indep = (output_pair_mode == OUTPUT_PAIR_MODE_INDEP);
  assign ov_en_wr = {output_io_control_q[IO_OVEN_H_BIT], output_io_control_q[IO_OVEN_L_BIT]};
  assign override_value_wr = {output_io_control_q[IO_OVVAL_H_BIT],
                              output_io_control_q[IO_OVVAL_L_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Master time base and the two local time bases
  logic [W-1:0] mst_q;
  logic mst_wrap;
  assign mst_wrap = pwm_module_on && (mst_q >= period_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mst_q <= '0;
    end else if (!pwm_module_on || mst_wrap) begin
      mst_q <= '0;
    end else begin
      mst_q <= mst_q + W'(1);
    end
  end

  logic [W-1:0] per_h;
  logic load_h;
  logic [W-1:0] per_l;
  logic load_l;
  logic [W-1:0] val_l;
  logic [W-1:0] cnt_h;
  logic [W-1:0] cnt_l;
  logic wrap_h;
  logic wrap_l;

  // Shared base: phase loaded at master wrap; own base: phase is the period
  assign per_h = independent_timebase_sel ? primary_phase_value_q : period_q;
  assign load_h = !independent_timebase_sel && mst_wrap;
  // Paired modes run the low base as a copy of the high one
  assign per_l = !indep ? per_h :
                 (independent_timebase_sel ? secondary_phase_value_q : period_q);
  assign load_l = !indep ? load_h : (!independent_timebase_sel && mst_wrap);
  assign val_l = indep ? secondary_phase_value_q : primary_phase_value_q;

  pwmpt_timebase #(.W(W)) u_tb_high (
    .clk(clk),
    .reset_n(reset_n),
    .run(pwm_module_on),
    .load(load_h),
    .load_val(primary_phase_value_q),
    .period(per_h),
    .cnt_q(cnt_h),
    .wrap(wrap_h)
  );

  pwmpt_timebase #(.W(W)) u_tb_low (
    .clk(clk),
    .reset_n(reset_n),
    .run(pwm_module_on),
    .load(load_l),
    .load_val(val_l),
    .period(per_l),
    .cnt_q(cnt_l),
    .wrap(wrap_l)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Raw waveforms per output mode
  logic pp_q;
  logic base_h;
  logic raw_h;
  logic raw_l;
  assign base_h = pwm_module_on && (cnt_h < duty_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pp_q <= 1'b0;
    end else if (!pwm_module_on) begin
      pp_q <= 1'b0;
    end else if (wrap_h) begin
      pp_q <= !pp_q;
    end
  end

  always_comb begin
    raw_h = base_h;
    raw_l = 1'b0;
    unique case (output_pair_mode)
      OUTPUT_PAIR_MODE_COMPL: begin
        raw_l = pwm_module_on && !base_h;
      end
      OUTPUT_PAIR_MODE_REDUN: begin
        raw_l = base_h;
      end
      OUTPUT_PAIR_MODE_PUSHPULL: begin
        raw_h = base_h && !pp_q;
        raw_l = base_h && pp_q;
      end
      OUTPUT_PAIR_MODE_INDEP: begin
        raw_l = pwm_module_on && (cnt_l < duty_q);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override state: held until a high time base wrap when synchronised and running
  logic [1:0] ov_en_q;
  logic [1:0] override_value_q;
  logic ov_take;
  assign ov_take = override_sync ? (wrap_h || !pwm_module_on) : 1'b1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_en_q <= 2'b00;
      override_value_q <= 2'b00;
    end else if (ov_take) begin
      ov_en_q <= ov_en_wr;
      override_value_q <= override_value_wr;
    end
  end

  logic sel_h;
  logic sel_l;
  assign sel_h = ov_en_q[1] ? override_value_q[1] : raw_h;
  assign sel_l = ov_en_q[0] ? override_value_q[0] : raw_l;

  ////////////////////////////////////////////////////////////////////////////
  // Pins and trigger, all registered
  logic high_q;
  logic low_q;
  logic trig_q;
  logic match;
  logic match_q;
  assign match = pwm_module_on && (cnt_h == trigger_compare_value_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      high_q <= swap ? sel_l : sel_h;
      low_q <= swap ? sel_h : sel_l;
    end
  end

  // Edge of the match, so a stalled counter cannot hold the trigger high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      match_q <= match;
      trig_q <= match && !match_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the first request cycle, while waitrequest is still high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_q <= 32'h00000000;
    end else if (avs_read && waitrequest_q) begin
      readdata_q <= 32'h00000000;
      unique case (word_addr)
        OFS_PRI_PHASE: readdata_q[15:0] <= primary_phase_value_q;
        OFS_SEC_PHASE: readdata_q[15:0] <= secondary_phase_value_q;
        OFS_IO_CTRL: readdata_q[15:0] <= output_io_control_q;
        OFS_TRIG_CMP: readdata_q[15:0] <= trigger_compare_value_q;
        OFS_GEN_CTRL: readdata_q[15:0] <= generator_control_q;
        OFS_PERIOD: readdata_q[15:0] <= period_q;
        OFS_DUTY: readdata_q[15:0] <= duty_q;
        OFS_STATUS: begin
          readdata_q[15:0] <= cnt_h;
          readdata_q[STAT_OPEN_BIT] <= (unlock_q == UL_OPEN);
        end
        default: begin
        end
      endcase
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;
  assign high_side_output = high_q;
  assign low_side_output = low_q;
  assign adc_trigger = trig_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic [1:0] swap_sel;
  assign swap_sel = swap ? {sel_l, sel_h} : {sel_h, sel_l};

  a_trig_single: assert property (trig_q |=> !trig_q)
    else $error("adc trigger longer than one cycle");

  a_trig_cause: assert property (trig_q |-> $past(match) && !$past(match_q))
    else $error("adc trigger without compare match");

  a_swap_route: assert property ({high_q, low_q} == $past(swap_sel))
    else $error("output routing does not follow swap");

  a_phase_load: assert property (
    (!independent_timebase_sel && mst_wrap) |=>
      (cnt_h == $past(primary_phase_value_q)) || !pwm_module_on)
    else $error("primary phase not loaded at master wrap");

  a_itb_period: assert property (
    (independent_timebase_sel && pwm_module_on && cnt_h == primary_phase_value_q) |=>
      cnt_h == 16'h0000)
    else $error("own time base did not wrap at primary phase");

  a_indep_shift: assert property (
    (indep && !independent_timebase_sel && mst_wrap) |=>
      (cnt_l == $past(secondary_phase_value_q)) || !pwm_module_on)
    else $error("secondary phase not loaded in independent mode");

  a_indep_period: assert property (
    (indep && independent_timebase_sel && pwm_module_on &&
     cnt_l == secondary_phase_value_q) |=> cnt_l == 16'h0000)
    else $error("low time base did not wrap at secondary phase");

  a_paired_copy: assert property (
    (!indep && cnt_l == cnt_h) |=> (cnt_l == cnt_h) || indep)
    else $error("paired low time base diverged from high");

  a_lock_reject: assert property (
    (wr_ok && word_addr == OFS_IO_CTRL && pwm_write_lock && unlock_q != UL_OPEN) |=>
      $stable(output_io_control_q))
    else $error("locked output control register was written");

  a_ovr_hold: assert property (
    (override_sync && pwm_module_on && !wrap_h) |=> $stable(ov_en_q))
    else $error("synchronised override changed before wrap");

  a_ovr_next: assert property (!override_sync |=> ov_en_q == $past(ov_en_wr))
    else $error("unsynchronised override not applied next clock");

  a_bus_answer: assert property ((req && waitrequest_q) |=> !waitrequest_q ##1 waitrequest_q)
    else $error("bus answer not one cycle after request");

  c_trigger: cover property (trig_q);
  c_swap_on: cover property (swap && high_q != low_q);
  c_indep_wrap: cover property (indep && independent_timebase_sel && wrap_l);
  c_unlock_wr: cover property (wr_ok && word_addr == OFS_IO_CTRL && pwm_write_lock &&
                               unlock_q == UL_OPEN);

endmodule

//--- verification/pwmpt_stage.sv
// Power stage model: counts on-cycles of each gate and cycles where they differ.
// Assumes gates are registered on the block clock; clr opens a new window.
`timescale 1ns/1ps
module pwmpt_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Gate drives and window control
  input wire logic gate_h,
  input wire logic gate_l,
  input wire logic clr,
  // Window counts
  output logic [15:0] h_on,
  output logic [15:0] l_on,
  output logic [15:0] diff
);
  // Counting only, so any waveform the block makes is accepted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      h_on <= 16'h0000;
      l_on <= 16'h0000;
      diff <= 16'h0000;
    end else if (clr) begin
      // New window starts from zero on the clock, not as a reset
      h_on <= 16'h0000;
      l_on <= 16'h0000;
      diff <= 16'h0000;
    end else begin
      h_on <= h_on + {15'h0000, gate_h};
      l_on <= l_on + {15'h0000, gate_l};
      diff <= diff + {15'h0000, gate_h ^ gate_l};
    end
  end
endmodule

//--- verification/pwm_phase_trigger_outputs_bench.sv
// Self-checking bench for the PWM phase, trigger and output block.
// Assumes pwmpt_top and pwmpt_stage; registers reached over Avalon-MM.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module pwm_phase_trigger_outputs_bench;
  import pwmpt_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  logic lock = 1'b0;
  logic out_h;
  logic out_l;
  logic trig;
  logic clr = 1'b0;
  logic [15:0] h_on;
  logic [15:0] l_on;
  logic [15:0] diff;
  logic [31:0] got;
  logic [15:0] ovr [4] = '{16'h0380, 16'h0382, 16'h0340, 16'h0342};
  logic [1:0] pins [4] = '{2'b10, 2'b01, 2'b01, 2'b10};
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int g;
  int n;

  always #5 clk = ~clk;

  pwmpt_top uut (.clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .pwm_write_lock(lock),
    .high_side_output(out_h), .low_side_output(out_l), .adc_trigger(trig));
  pwmpt_stage stage (.clk(clk), .reset_n(reset_n), .gate_h(out_h), .gate_l(out_l),
    .clr(clr), .h_on(h_on), .l_on(l_on), .diff(diff));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run is under two thousand cycles; this only cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, d};
    wr_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr_en <= 1'b0;
  endtask

  // Plain read: the whole word lands in got
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    got = rdata;
    rd_en <= 1'b0;
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [15:0] ex, input string nm);
    rd(a);
    `CHK(nm, {16'h0000, ex}, got)
  endtask

  task automatic win(input int c);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Spacing between two trigger pulses; also checks the pulse is one cycle
  task automatic tgap(output int gp);
    do @(posedge clk); while (trig !== 1'b1);
    @(posedge clk);
    `CHK("trigger width", 1'b0, trig)
    gp = 1;
    do begin @(posedge clk); gp++; end while (trig !== 1'b1);
  endtask

  task automatic pins_after(input logic [1:0] ex);
    repeat (2) @(posedge clk);
    #1;
    `CHK("pins", ex, {out_h, out_l})
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    chk_rd(OFS_PRI_PHASE, RST_PRI_PHASE, "primary reset");
    chk_rd(OFS_SEC_PHASE, RST_SEC_PHASE, "secondary reset");
    chk_rd(OFS_IO_CTRL, RST_IO_CTRL, "io control reset");
    chk_rd(OFS_TRIG_CMP, RST_TRIG_CMP, "trigger reset");
    chk_rd(OFS_PERIOD, RST_PERIOD, "period reset");
    wr(OFS_SEC_PHASE, 16'hA5C3);
    chk_rd(OFS_SEC_PHASE, 16'hA5C3, "secondary");
    wr(OFS_TRIG_CMP, 16'hFFFF);
    chk_rd(OFS_TRIG_CMP, 16'hFFFF, "trigger compare");
    wr(6'h24, 16'h1234);
    chk_rd(6'h24, 16'h0000, "unmapped");
    chk_rd(OFS_UNLOCK, 16'h0000, "unlock reads");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IO_CTRL, ovr[i]);
      pins_after(pins[i]);
    end
    // Lock held static around each group of accesses
    @(posedge clk);
    lock <= 1'b1;
    wr(OFS_IO_CTRL, 16'h0380);
    chk_rd(OFS_IO_CTRL, 16'h0342, "locked write");
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    // Module is off, so the status count reads zero beside the open flag
    rd(OFS_STATUS);
    `CHK("status open", 32'h00010000, got)
    wr(OFS_IO_CTRL, 16'h0380);
    chk_rd(OFS_IO_CTRL, 16'h0380, "unlocked write");
    wr(OFS_IO_CTRL, 16'h0000);
    chk_rd(OFS_IO_CTRL, 16'h0380, "unlock consumed");
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, 16'h1111);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_IO_CTRL, 16'h0000);
    chk_rd(OFS_IO_CTRL, 16'h0380, "wrong key");
    lock <= 1'b0;
    wr(OFS_IO_CTRL, 16'h0000);
    wr(OFS_PERIOD, 16'h0009);
    wr(OFS_DUTY, 16'h0004);
    wr(OFS_TRIG_CMP, 16'h0003);
    wr(OFS_SEC_PHASE, 16'h0007);
    wr(OFS_GEN_CTRL, 16'h0001);
    tgap(g);
    `CHK("trigger gap", 10, g)
    win(100);
    `CHK("compl high", 16'd40, h_on)
    `CHK("compl diff", 16'd100, diff)
    // Mode changes only; swap and sync stay as they are while running
    wr(OFS_PRI_PHASE, 16'h0003);
    wr(OFS_IO_CTRL, 16'h0400);
    repeat (25) @(posedge clk);
    win(100);
    `CHK("redundant high", 16'd40, h_on)
    `CHK("redundant diff", 16'd0, diff)
    wr(OFS_IO_CTRL, 16'h0800);
    repeat (25) @(posedge clk);
    win(100);
    `CHK("pushpull high", 16'd20, h_on)
    `CHK("pushpull low", 16'd20, l_on)
    wr(OFS_PRI_PHASE, 16'h0000);
    wr(OFS_SEC_PHASE, 16'h0000);
    wr(OFS_IO_CTRL, 16'h0C00);
    repeat (25) @(posedge clk);
    win(100);
    `CHK("indep diff", 16'd0, diff)
    wr(OFS_SEC_PHASE, 16'h0003);
    repeat (25) @(posedge clk);
    win(100);
    `CHK("indep shifted", 1'b1, diff != 16'd0)
    wr(OFS_GEN_CTRL, 16'h0000);
    wr(OFS_PRI_PHASE, 16'h0005);
    wr(OFS_DUTY, 16'h0002);
    wr(OFS_GEN_CTRL, 16'h0201);
    tgap(g);
    `CHK("own base gap", 6, g)
    win(60);
    `CHK("own high", 16'd20, h_on)
    `CHK("own low", 16'd30, l_on)
    wr(OFS_IO_CTRL, 16'h0400);
    repeat (25) @(posedge clk);
    win(60);
    `CHK("own paired low", 16'd20, l_on)
    `CHK("own paired diff", 16'd0, diff)
    wr(OFS_GEN_CTRL, 16'h0000);
    wr(OFS_PERIOD, 16'd200);
    wr(OFS_IO_CTRL, 16'h0381);
    pins_after(2'b10);
    wr(OFS_GEN_CTRL, 16'h0001);
    wr(OFS_IO_CTRL, 16'h0341);
    pins_after(2'b10);
    n = 0;
    while (out_l !== 1'b1 && n < 260) begin @(posedge clk); n++; end
    `CHK("sync at wrap", 1'b1, n > 150 && n < 220)
    end_of_test();
  end
endmodule
